/* hw/eer_top.sv */
// Serial EEPROM read path: link slave on link_clk, memory on clk_sys
`default_nettype none

// What this block does
// RULE1: The master sets the read pointer by first starting a write-type transaction.
// RULE2: The pointer load is START, address with direction 0, then two address bytes, no data.
// RULE3: The master then sends a repeated START and the address with direction 1.
// RULE4: The device acknowledges every byte the master sends in the load and request phases.
// RULE5: After acknowledging a read request the device shifts out the byte at the pointer.
// RULE6: The master ends a read with no acknowledge on the last byte and then a STOP.
// RULE7: An acknowledged data byte is followed by the next byte until no-acknowledge and STOP.
// RULE8: The pointer advances after each byte sent and wraps from the top to address zero.
// RULE9: Only an address of 1010 plus the three strap levels is answered.
// RULE10: In the ninth clock the transmitter releases SDA and the receiver acks low or not.
// RULE11: SDA is sampled on SCL rise, changed after SCL fall, and driven open drain.
// RULE12: While a programming cycle runs the slave address is not acknowledged.
// RULE13: The pointer is 13 bits and higher bits of the address bytes are dropped.
// RULE14: After STOP the device releases SDA, idles, and keeps its pointer.

module eer_top
    import eer_pkg::*;
#(
    parameter int ADDR_W = eer_pkg::MEM_ADDR_W
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 link_clk,
    input  wire eer_pkg::eer_bus_in_t link_pins,
    input  wire eer_pkg::eer_strap_t  strap,
    input  wire eer_pkg::eer_fill_t   fill,
    input  wire logic                 prog_busy,
    output var  logic                 sda_val,
    output var  logic                 sda_oe_n
);
    import eer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic              lrst_m_reg, lrst_n;
    logic              scl_m_reg, scl_s_reg, scl_d_reg;
    logic              sda_m_reg, sda_s_reg, sda_d_reg;
    logic [2:0]        strap_m_reg, strap_s_reg;
    logic              prog_m_reg, prog_s_reg;
    eer_state_t        state_reg, state_next;
    logic [3:0]        cnt_reg, cnt_next;
    logic [7:0]        sh_reg, sh_next;
    logic              mack_reg, mack_next;
    logic              oe_n_reg, oe_n_next;
    logic              sda_o_reg;
    logic [ADDR_W-1:0] ptr_reg, ptr_next;
    logic              ptr_upd, pend_reg, pend_next;
    logic              req_tgl_reg, ack_tgl_reg;
    logic [ADDR_W-1:0] req_addr_reg;
    logic              ack_m_reg, ack_s_reg, ack_d_reg;
    logic [7:0]        pf_reg, rdata_reg;
    logic              sreq_m_reg, sreq_s_reg, sreq_d_reg;

    // Keep the low ADDR_W bits of a two-byte address
    function automatic logic [ADDR_W-1:0] fit_addr(input logic [15:0] wide);
        return wide[ADDR_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link condition decode
    wire        rise     = scl_s_reg & ~scl_d_reg;
    wire        fall     = ~scl_s_reg & scl_d_reg;
    wire        start    = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    wire        stop     = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    wire        dev_hit  = (sh_reg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE) &&
                           (sh_reg[DEV_SEL_MSB:DEV_SEL_LSB] == strap_s_reg);
    wire        dev_ok   = dev_hit & ~prog_s_reg;
    wire        rx_ack   = (state_reg == ST_DEV) ? dev_ok : 1'b1;
    wire [15:0] ptr_wide = 16'(ptr_reg);
    wire        busy     = req_tgl_reg ^ ack_d_reg;
    wire        issue    = pend_reg & ~busy;
    wire        ack_edge = ack_s_reg ^ ack_d_reg;
    wire        sreq_edge = sreq_s_reg ^ sreq_d_reg;
    wire        lfall    = fall && cnt_reg == CNT_LAST;  // Fall closing the eighth bit
    wire        afall    = fall && cnt_reg == CNT_ACK;   // Fall closing the ninth clock

    // Link reset, released in step with link_clk
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_m_reg <= 1'b0;
            lrst_n     <= 1'b0;
        end else begin
            lrst_m_reg <= 1'b1;
            lrst_n     <= lrst_m_reg;
        end
    end

    // Pin synchronisers and edge history
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
            {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
            strap_m_reg <= 3'h0;
            strap_s_reg <= 3'h0;
            {prog_m_reg, prog_s_reg}          <= 2'h0;
            {ack_m_reg, ack_s_reg, ack_d_reg} <= 3'h0;
        end else begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= {link_pins.scl, scl_m_reg, scl_s_reg}; // RULE11
            {sda_m_reg, sda_s_reg, sda_d_reg} <= {link_pins.sda, sda_m_reg, sda_s_reg};
            strap_m_reg <= {strap.slave_select_strap_hi, strap.slave_select_strap_mid,
                            strap.slave_select_strap_lo};
            strap_s_reg <= strap_m_reg;
            {prog_m_reg, prog_s_reg}          <= {prog_busy, prog_m_reg};
            {ack_m_reg, ack_s_reg, ack_d_reg} <= {ack_tgl_reg, ack_m_reg, ack_s_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link state machine next values
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        mack_next  = mack_reg;
        oe_n_next  = oe_n_reg;
        ptr_next   = ptr_reg;
        ptr_upd    = 1'b0;
        if (stop) begin
            state_next = ST_IDLE; // RULE14
            oe_n_next  = 1'b1;
        end else if (start) begin
            state_next = ST_DEV;
            cnt_next   = CNT_ZERO;
            oe_n_next  = 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_IGN: begin
                    oe_n_next = 1'b1;
                end
                ST_TX: begin
                    if (rise && cnt_reg == CNT_LAST) begin
                        mack_next = ~sda_s_reg; // RULE10
                        cnt_next  = CNT_ACK;
                    end else if (rise && cnt_reg < CNT_LAST) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && cnt_reg == CNT_LAST) begin
                        oe_n_next = 1'b1; // RULE10
                    end else if (fall && cnt_reg == CNT_ACK) begin
                        if (mack_reg) begin
                            sh_next   = pf_reg; // RULE7
                            oe_n_next = pf_reg[7];
                            cnt_next  = CNT_ZERO;
                            ptr_next  = ptr_reg + 1'b1; // RULE8
                            ptr_upd   = 1'b1;
                        end else begin
                            state_next = ST_IGN; // RULE7
                        end
                    end else if (fall && cnt_reg != CNT_ZERO) begin
                        sh_next   = {sh_reg[6:0], 1'b0}; // RULE11
                        oe_n_next = sh_reg[6];
                    end
                end
                ST_DEV, ST_AHI, ST_ALO: begin
                    if (rise && cnt_reg < CNT_LAST) begin
                        sh_next  = {sh_reg[6:0], sda_s_reg}; // RULE11
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall && cnt_reg == CNT_LAST) begin
                        oe_n_next = ~rx_ack; // RULE4 RULE9 RULE12
                        cnt_next  = CNT_ACK;
                        if (!rx_ack) begin
                            state_next = ST_IGN;
                        end
                    end else if (fall && cnt_reg == CNT_ACK) begin
                        oe_n_next = 1'b1;
                        cnt_next  = CNT_ZERO;
                        if (state_reg == ST_DEV && sh_reg[DEV_RW_BIT]) begin
                            state_next = ST_TX; // RULE5
                            sh_next    = pf_reg;
                            oe_n_next  = pf_reg[7];
                            ptr_next   = ptr_reg + 1'b1; // RULE8
                            ptr_upd    = 1'b1;
                        end else if (state_reg == ST_DEV) begin
                            state_next = ST_AHI;
                        end else if (state_reg == ST_AHI) begin
                            ptr_next   = fit_addr({sh_reg, ptr_wide[7:0]}); // RULE13
                            state_next = ST_ALO;
                        end else begin
                            ptr_next   = fit_addr({ptr_wide[15:8], sh_reg}); // RULE13
                            ptr_upd    = 1'b1;
                            state_next = ST_IGN;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_n_next  = 1'b1;
                end
            endcase
        end
    end

    // Byte fetch request, set wins over issue
    assign pend_next = (pend_reg & ~issue) | ptr_upd;

    // Link state registers
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_ZERO;
            sh_reg    <= 8'h00;
            mack_reg  <= 1'b0;
            oe_n_reg  <= OE_N_RST;
            sda_o_reg <= 1'b0;
            ptr_reg   <= '0;
            pend_reg  <= PEND_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            mack_reg  <= mack_next;
            oe_n_reg  <= oe_n_next;
            sda_o_reg <= 1'b0; // RULE11
            ptr_reg   <= ptr_next; // RULE14
            pend_reg  <= pend_next;
        end
    end

    // Fetch handshake, link side
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            req_tgl_reg  <= 1'b0;
            req_addr_reg <= '0;
            pf_reg       <= 8'h00;
        end else begin
            if (issue) begin
                req_tgl_reg  <= ~req_tgl_reg;
                req_addr_reg <= ptr_reg;
            end
            if (ack_edge) begin
                pf_reg <= rdata_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory array and preload
    always_ff @(posedge clk_sys) begin
        if (fill.valid) begin
            mem[fill.addr[ADDR_W-1:0]] <= fill.data;
        end
    end

    // Fetch handshake, system side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {sreq_m_reg, sreq_s_reg, sreq_d_reg} <= 3'h0;
            ack_tgl_reg <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            {sreq_m_reg, sreq_s_reg, sreq_d_reg} <= {req_tgl_reg, sreq_m_reg, sreq_s_reg};
            if (sreq_edge) begin
                rdata_reg   <= mem[req_addr_reg];
                ack_tgl_reg <= ~ack_tgl_reg;
            end
        end
    end

    assign sda_val  = sda_o_reg;
    assign sda_oe_n = oe_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!lrst_n);

    AST_DEV_ACK: assert property (state_reg == ST_DEV && lfall && dev_ok // RULE9
        |=> !sda_oe_n ##1 !sda_oe_n) else $error("matching address not acknowledged");
    AST_BUSY_NACK: assert property (state_reg == ST_DEV && lfall && prog_s_reg // RULE12
        |=> sda_oe_n && state_reg == ST_IGN) else $error("address acked while busy");
    AST_ADDR_ACK: assert property ((state_reg == ST_AHI || state_reg == ST_ALO) // RULE4
        && lfall |=> !sda_oe_n) else $error("address byte not acknowledged");
    AST_STOP_IDLE: assert property (stop |=> state_reg == ST_IDLE && sda_oe_n // RULE14
        && ptr_reg == $past(ptr_reg)) else $error("stop did not release and idle");
    AST_FIRST_BYTE: assert property (state_reg == ST_DEV && afall && sh_reg[0] // RULE5
        |=> state_reg == ST_TX && sh_reg == $past(pf_reg)) else $error("wrong first byte");
    AST_PTR_INC: assert property (state_reg == ST_TX && afall && mack_reg // RULE8
        |=> ptr_reg == ADDR_W'($past(ptr_reg) + 1'b1)) else $error("pointer not advanced");
    AST_MACK_RELEASE: assert property (state_reg == ST_TX && cnt_reg == CNT_ACK // RULE10
        |-> sda_oe_n) else $error("sda held during master acknowledge");
    AST_SDA_AFTER_FALL: assert property ($changed(sda_oe_n) // RULE11
        |-> $past(fall) || $past(start) || $past(stop)) else $error("sda changed outside scl low");
    AST_NACK_END: assert property (state_reg == ST_TX && afall && !mack_reg // RULE7
        |=> state_reg == ST_IGN ##1 sda_oe_n) else $error("no-acknowledge did not end sending");
    AST_FETCH_DONE: assert property (issue |-> ##[1:15] ack_edge)
        else $error("fetch request not answered");

    COV_READ: cover property (state_reg == ST_DEV ##1 state_reg == ST_TX);
    COV_BURST: cover property (state_reg == ST_TX && fall && cnt_reg == CNT_ACK && mack_reg);
    COV_WRAP: cover property (ptr_upd && ptr_reg == '1 && state_reg == ST_TX);
    COV_BUSY: cover property (state_reg == ST_DEV && fall && cnt_reg == CNT_LAST && prog_s_reg);

endmodule

`default_nettype wire

/* hw/eer_pkg.sv */
// Shared constants and types for the serial EEPROM read path
`default_nettype none

package eer_pkg;

    // Slave address layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;  // Fixed upper nibble of the slave address
    localparam int         DEV_TYPE_MSB  = 7;
    localparam int         DEV_TYPE_LSB  = 4;
    localparam int         DEV_SEL_MSB   = 3;
    localparam int         DEV_SEL_LSB   = 1;
    localparam int         DEV_RW_BIT    = 0;     // 1 = read, 0 = write

    // Memory geometry
    localparam int         MEM_ADDR_W    = 13;
    localparam int         BYTE_W        = 8;

    // Bit counter marks within one byte frame
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_LAST      = 4'h8;  // Eight data bits seen
    localparam logic [3:0] CNT_ACK       = 4'h9;  // Inside the ninth clock

    // Reset values
    localparam logic       OE_N_RST      = 1'b1;  // Released
    localparam logic       PEND_RST      = 1'b1;  // Fetch byte zero after reset

    // Link state machine, Gray coded in the order listed
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_AHI  = 3'b011,
        ST_ALO  = 3'b010,
        ST_TX   = 3'b110,
        ST_IGN  = 3'b111
    } eer_state_t;

    // Link pins sampled from the bus
    typedef struct packed {
        logic scl;
        logic sda;
    } eer_bus_in_t;

    // Slave select straps
    typedef struct packed {
        logic slave_select_strap_hi;
        logic slave_select_strap_mid;
        logic slave_select_strap_lo;
    } eer_strap_t;

    // Memory preload port
    typedef struct packed {
        logic                  valid;
        logic [MEM_ADDR_W-1:0] addr;
        logic [BYTE_W-1:0]     data;
    } eer_fill_t;

endpackage

`default_nettype wire

/* bench/eer_master_model.sv */
// Behavioural link master: drives the clock line and its share of the data line
`default_nettype none

module eer_master_model (
    input  wire logic clk_sys,
    input  wire logic sda_bus,
    output var  logic scl,
    output var  logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Quarter bit time, 60 ns
    task automatic q();
        repeat (6) @(posedge clk_sys);
    endtask

    // One clock: data set while low, sampled mid high
    task automatic bit_out(input logic b, output logic seen);
        q();
        sda_drv <= b;
        q();
        scl <= 1'b1;
        q();
        seen = sda_bus;
        q();
        scl <= 1'b0;
    endtask

    // Start or repeated start
    task automatic start();
        q();
        sda_drv <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_drv <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask

    // Stop condition ends the frame
    task automatic stop();
        q();
        sda_drv <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_drv <= 1'b1;
        q();
    endtask

    // Byte sent MSB first, line released in the ninth clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i], s);
        end
        bit_out(1'b1, s);
        ack = ~s;
    endtask

    // Byte received, then ack low or no-ack high
    task automatic rbyte(input logic give_ack, output logic [7:0] d, output logic lvl);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_out(1'b1, s);
            d[i] = s;
        end
        bit_out(~give_ack, lvl);
    endtask
endmodule

`default_nettype wire

/* bench/eer_top_bench.sv */
// Self-checking bench for the serial EEPROM read path
`default_nettype none

module eer_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eer_pkg::*;

    logic        clk_sys;
    logic        link_clk;
    logic        rst_n;
    eer_strap_t  strap;
    eer_fill_t   fill;
    logic        prog_busy;
    logic        sda_val;
    logic        sda_oe_n;
    logic        scl_w;
    logic        sda_drv;
    logic        sda_line;
    eer_bus_in_t bus_in;
    logic [2:0]  my_sel;
    logic        ack;
    logic        lvl;
    logic [7:0]  d;
    int          mem_model [8192];
    int          ptr;
    int          miscompares;
    int          checks_done;

    // Wired-AND data line with pull-up
    assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_val);
    assign bus_in = '{scl: scl_w, sda: sda_line};

    eer_top #(.ADDR_W(13)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk), .link_pins(bus_in),
        .strap(strap), .fill(fill), .prog_busy(prog_busy), .sda_val(sda_val),
        .sda_oe_n(sda_oe_n));

    eer_master_model mst (.clk_sys(clk_sys), .sda_bus(sda_line), .scl(scl_w), .sda_drv(sda_drv));

    // Clocks, link clock offset in phase
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Start plus address byte, ack expectation given
    task automatic addr_phase(input logic [7:0] ab, input logic exp_ack);
        mst.start();
        mst.wbyte(ab, ack);
        check_bit("address ack", exp_ack, ack);
    endtask

    // Dummy write that loads the pointer
    task automatic load_ptr(input logic [15:0] a);
        addr_phase({DEV_TYPE_CODE, my_sel, 1'b0}, 1'b1);
        mst.wbyte(a[15:8], ack);
        check_bit("high address ack", 1'b1, ack);
        mst.wbyte(a[7:0], ack);
        check_bit("low address ack", 1'b1, ack);
        ptr = int'(a[12:0]);
    endtask

    // Read n bytes at the pointer, no-ack on the last, then stop
    task automatic read_burst(input int n);
        addr_phase({DEV_TYPE_CODE, my_sel, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            mst.rbyte(i != n - 1, d, lvl);
            check_byte("read data", 8'(mem_model[ptr]), d);
            check_bit("ninth clock level", i == n - 1, lvl);
            ptr = (ptr + 1) % 8192;
        end
        mst.stop();
        repeat (3) @(posedge clk_sys);
        check_bit("released after stop", 1'b1, sda_oe_n);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h26dc17bf));
        miscompares = 0;
        checks_done = 0;
        rst_n = 1'b0;
        prog_busy = 1'b0;
        fill = '0;
        strap = eer_strap_t'(3'($urandom_range(7, 0)));
        my_sel = strap;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Preload the whole array with random bytes
        for (int a = 0; a < 8192; a++) begin
            @(posedge clk_sys);
            mem_model[a] = int'($urandom_range(255, 0));
            fill <= '{valid: 1'b1, addr: 13'(a), data: 8'(mem_model[a])};
        end
        @(posedge clk_sys);
        fill <= '0;
        repeat (30) @(posedge clk_sys);
        // Selective reads at random addresses, upper bits random
        for (int k = 0; k < 3; k++) begin
            load_ptr(16'($urandom()));
            read_burst(1 + k);
        end
        load_ptr(16'hfffe);
        read_burst(5);
        read_burst(2);
        // Foreign select codes and a foreign type code are ignored
        for (int s = 0; s < 8; s++) begin
            if (3'(s) != my_sel) begin
                addr_phase({DEV_TYPE_CODE, 3'(s), 1'($urandom())}, 1'b0);
                mst.stop();
            end
        end
        addr_phase({4'hb, my_sel, 1'b1}, 1'b0);
        mst.stop();
        // Programming cycle running: no ack
        prog_busy <= 1'b1;
        repeat (10) @(posedge clk_sys);
        addr_phase({DEV_TYPE_CODE, my_sel, 1'b1}, 1'b0);
        mst.stop();
        prog_busy <= 1'b0;
        repeat (10) @(posedge clk_sys);
        read_burst(2);
        tally_and_finish();
    end
endmodule

`default_nettype wire
